/* logic/mioc_regs.vh */
`ifndef MIOC_REGS_VH
`define MIOC_REGS_VH
// Operation codes presented on the op port
`define MIOC_OP_NONE      3'h0
`define MIOC_OP_OR_REG    3'h1
`define MIOC_OP_FPAGE_WR  3'h2
`define MIOC_OP_FPAGE_RD  3'h3
`define MIOC_OP_LBRANCH   3'h4
`define MIOC_OP_LONG_CALL     3'h5
`define MIOC_OP_MOVE_REG  3'h6
// Function page operand range
`define MIOC_FPAGE_MIN    4'h5
`define MIOC_FPAGE_MAX    4'hF
// Reset values and step sizes
`define MIOC_ACC_RST      8'h00
`define MIOC_PC_RST       11'h000
`define MIOC_SP_RST       3'h0
`define MIOC_PC_STEP      11'h001
`define MIOC_SP_STEP      3'h1
`endif

/* logic/mioc_stack.v */
`timescale 1ns/1ns
// Return address stack, push only from this block
module mioc_stack #(
	parameter DEPTH_LOG = 3,
	parameter AW        = 11
) (
	input  wire                 mclk,
	input  wire                 rst,
	input  wire                 push,
	input  wire [AW-1:0]        push_addr,
	output reg  [DEPTH_LOG-1:0] level,
	output reg  [AW-1:0]        top
);
	// Stack storage
	reg [AW-1:0] mem [0:(1<<DEPTH_LOG)-1];

	////////////////////////////////////////////////////////////////////
	// Write the slot at the current level, then advance
	always @(posedge mclk) begin
		if (push) begin
			mem[level] <= push_addr;
		end
	end

	// Pointer and registered top copy
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			level <= {DEPTH_LOG{1'b0}};
			top   <= {AW{1'b0}};
		end else if (push) begin
			// RULE8: advance one level
			level <= level + {{(DEPTH_LOG-1){1'b0}}, 1'b1};
			top   <= push_addr;
		end
	end
endmodule // mioc_stack

/* logic/mioc_core.v */
`timescale 1ns/1ns
`include "mioc_regs.vh"
// Summary of operation
// RULE1: OR accumulator with register, set zero
// RULE2: destination bit picks accumulator or register
// RULE3: page write copies accumulator, flags kept
// RULE4: page read loads accumulator, flags kept
// RULE5: long branch loads PC, two cycles
// RULE6: long call pushes PC+1, loads PC
// RULE7: move accumulator to register, one cycle
// RULE8: each push advances stack pointer one
module mioc_core #(
	parameter SP_W = 3
) (
	// Clock and reset
	input  wire            mclk,
	input  wire            rst,
	// Instruction request
	input  wire            op_valid,
	input  wire [2:0]      op,
	// Operand fields, used only on the accepting edge
	input  wire [6:0]      reg_addr,
	input  wire            dest_bit,
	input  wire [3:0]      fpage_sel,
	input  wire [10:0]     target,
	// Read data returned by the register files
	input  wire [7:0]      reg_rdata,
	input  wire [7:0]      fpage_rdata,
	// Handshake
	output wire            op_ready,
	// Data register write
	output reg             reg_we,
	output reg  [6:0]      reg_waddr,
	output reg  [7:0]      reg_wdata,
	// Function page write
	output reg             fpage_we,
	output reg  [3:0]      fpage_waddr,
	output reg  [7:0]      fpage_wdata,
	// Core state
	output reg  [7:0]      accumulator,
	output reg             zero_flag,
	output reg  [10:0]     pc,
	// Return stack view
	output wire [SP_W-1:0] stack_level,
	output wire [10:0]     stack_top,
	// Completion
	output reg             done
);
	// Sequencer states
	localparam ST_RUN  = 1'b0;
	localparam ST_WAIT = 1'b1;
	// Program counter width, fixed by the 11-bit branch target
	localparam PC_W    = 11;

	reg        state;      // Current state
	reg        next_state; // Following state
	wire       take;       // Instruction accepted
	wire [7:0] or_result;  // OR of accumulator and register
	wire       fpage_ok;   // Page operand inside legal range
	reg        push;       // Stack push strobe
	// Return address: the instruction after the call
	wire [PC_W-1:0] ret_addr;

	// Page operand range check, used by both page instructions
	function in_fpage;
		input [3:0] sel;
		begin
			in_fpage = (sel >= `MIOC_FPAGE_MIN) && (sel <= `MIOC_FPAGE_MAX);
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Accept only when no two-cycle instruction is pending
	assign op_ready  = (state == ST_RUN);
	assign take      = op_valid & op_ready;
	// RULE1: bitwise OR
	assign or_result = accumulator | reg_rdata;
	assign fpage_ok  = in_fpage(fpage_sel);
	// Wraps at the top of program space, as the counter does
	assign ret_addr  = pc + `MIOC_PC_STEP;

	// Push happens in the first cycle of a call
	always @* begin
		// RULE6: push next address
		push = take && (op == `MIOC_OP_LONG_CALL);
	end

	// Next state: branches and calls hold one extra cycle
	always @* begin
		next_state = state;
		case (state)
			ST_RUN: begin
				// RULE5: second cycle
				if (take && (op == `MIOC_OP_LBRANCH ||
				    op == `MIOC_OP_LONG_CALL)) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				// Second cycle over, accept again
				next_state = ST_RUN;
			end
			default: begin
				// Unreachable with a one-bit state
				next_state = ST_RUN;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Execute; write strobes are one-cycle pulses
	// Only the OR instruction touches the zero flag; every other
	// instruction leaves it as it was, which page and move rely on.
	// Page operands below the legal range are ignored, not trapped:
	// the counter still advances so the program keeps going.
	// Operands are sampled only on the accepting edge.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			// Idle strobes, cleared state
			state       <= ST_RUN;
			accumulator <= `MIOC_ACC_RST;
			zero_flag   <= 1'b0;
			pc          <= `MIOC_PC_RST;
			reg_we      <= 1'b0;
			reg_waddr   <= 7'h00;
			reg_wdata   <= 8'h00;
			fpage_we    <= 1'b0;
			fpage_waddr <= 4'h0;
			fpage_wdata <= 8'h00;
			done        <= 1'b0;
		end else begin
			state    <= next_state;
			reg_we   <= 1'b0;
			fpage_we <= 1'b0;
			done     <= 1'b0;
			// Finish of a two-cycle instruction
			if (state == ST_WAIT) begin
				done <= 1'b1;
			end
			if (take) begin
				case (op)
					`MIOC_OP_OR_REG: begin
						// RULE1: zero from result
						zero_flag <= (or_result == 8'h00);
						// RULE2: destination select
						if (dest_bit) begin
							// Register destination
							reg_we    <= 1'b1;
							reg_waddr <= reg_addr;
							reg_wdata <= or_result;
						end else begin
							// Accumulator destination
							accumulator <= or_result;
						end
						// Step past the instruction
						pc   <= pc + `MIOC_PC_STEP;
						done <= 1'b1;
					end
					`MIOC_OP_FPAGE_WR: begin
						// RULE3: page write
						if (fpage_ok) begin
							fpage_we    <= 1'b1;
							fpage_waddr <= fpage_sel;
							fpage_wdata <= accumulator;
						end
						// Step past the instruction, legal or not
						pc   <= pc + `MIOC_PC_STEP;
						done <= 1'b1;
					end
					`MIOC_OP_FPAGE_RD: begin
						// RULE4: page read
						if (fpage_ok) begin
							accumulator <= fpage_rdata;
						end
						// Source register is only read
						pc   <= pc + `MIOC_PC_STEP;
						done <= 1'b1;
					end
					`MIOC_OP_LBRANCH: begin
						// RULE5: load target
						pc <= target;
						// Done is set at the edge that ends the wait cycle
					end
					`MIOC_OP_LONG_CALL: begin
						// RULE6: load target
						pc <= target;
						// Stack takes the return address this edge
					end
					`MIOC_OP_MOVE_REG: begin
						// RULE7: store accumulator
						reg_we    <= 1'b1;
						reg_waddr <= reg_addr;
						reg_wdata <= accumulator;
						// Accumulator and flags untouched
						pc        <= pc + `MIOC_PC_STEP;
						done      <= 1'b1;
					end
					default: begin
						// Unknown code acts as no-op
						pc   <= pc + `MIOC_PC_STEP;
						done <= 1'b1;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Return stack
	// Own module, so the array stays beside its pointer
	// RULE8: pointer advance
	mioc_stack #(
		.DEPTH_LOG (SP_W),
		.AW        (PC_W)
	) mioc_stack_i (
		.mclk      (mclk),
		.rst       (rst),
		.push      (push),
		.push_addr (ret_addr),
		.level     (stack_level),
		.top       (stack_top)
	);
endmodule // mioc_core

/* dv/mioc_core_sva.sv */
`timescale 1ns/1ns
// Ties each taken instruction except the no-op codes and out-of-range page ops to its registered outcome
module mioc_core_sva #(
	parameter SP_W = 3
) (
	input wire            mclk,
	input wire            rst,
	input wire            op_valid,
	input wire            op_ready,
	input wire [2:0]      op,
	input wire [6:0]      reg_addr,
	input wire            dest_bit,
	input wire [3:0]      fpage_sel,
	input wire [10:0]     target,
	input wire [7:0]      reg_rdata,
	input wire [7:0]      fpage_rdata,
	input wire            reg_we,
	input wire [7:0]      reg_wdata,
	input wire            fpage_we,
	input wire [7:0]      fpage_wdata,
	input wire [7:0]      accumulator,
	input wire            zero_flag,
	input wire [10:0]     pc,
	input wire [SP_W-1:0] stack_level,
	input wire [10:0]     stack_top,
	input wire            done
);
	// Request taken at this edge
	wire tk = op_valid & op_ready;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Two-cycle ops refuse one cycle, then complete
	sequence s_two;
		!op_ready ##1 (done && op_ready);
	endsequence
	or_to_acc_a: assert property (tk && op == 3'h1 && !dest_bit |=>
		accumulator == ($past(accumulator) | $past(reg_rdata)) &&
		zero_flag == (accumulator == 8'h00) && done) else $error("or acc");
	or_to_reg_a: assert property (tk && op == 3'h1 && dest_bit |=>
		reg_we && reg_wdata == ($past(accumulator) | $past(reg_rdata)) &&
		$stable(accumulator)) else $error("or reg");
	page_write_a: assert property (tk && op == 3'h2 && fpage_sel > 4'h4 |=>
		fpage_we && fpage_wdata == $past(accumulator) && $stable(zero_flag))
		else $error("page write");
	page_read_a: assert property (tk && op == 3'h3 && fpage_sel > 4'h4 |=>
		accumulator == $past(fpage_rdata) && $stable(zero_flag) &&
		!fpage_we) else $error("page read");
	branch_load_a: assert property (tk && op == 3'h4 |=>
		pc == $past(target) ##0 s_two) else $error("branch");
	call_push_a: assert property (tk && op == 3'h5 |=>
		pc == $past(target) && stack_top == $past(pc) + 11'h001 ##0 s_two)
		else $error("call");
	move_reg_a: assert property (tk && op == 3'h6 |=>
		reg_we && reg_wdata == $past(accumulator) && $stable(accumulator))
		else $error("move");
	level_step_a: assert property (tk && op == 3'h5 |=>
		stack_level == $past(stack_level) + 3'h1) else $error("level");
endmodule // mioc_core_sva
bind mioc_core mioc_core_sva #(.SP_W(SP_W)) mioc_core_sva_i (
	.mclk        (mclk),
	.rst         (rst),
	.op_valid    (op_valid),
	.op_ready    (op_ready),
	.op          (op),
	.reg_addr    (reg_addr),
	.dest_bit    (dest_bit),
	.fpage_sel   (fpage_sel),
	.target      (target),
	.reg_rdata   (reg_rdata),
	.fpage_rdata (fpage_rdata),
	.reg_we      (reg_we),
	.reg_wdata   (reg_wdata),
	.fpage_we    (fpage_we),
	.fpage_wdata (fpage_wdata),
	.accumulator (accumulator),
	.zero_flag   (zero_flag),
	.pc          (pc),
	.stack_level (stack_level),
	.stack_top   (stack_top),
	.done        (done)
);

/* dv/test_mioc_core.sv */
`timescale 1ns/1ns
// One idle cycle before each op keeps strobes apart
module test_mioc_core;
	reg         mclk = 1'b0;
	reg         rst = 1'b1;
	reg         op_valid = 1'b0;
	reg  [2:0]  op = 3'h0;
	reg  [6:0]  reg_addr = 7'h00;
	reg         dest_bit = 1'b0;
	reg  [3:0]  fpage_sel = 4'h0;
	reg  [10:0] target = 11'h000;
	// Register files modelled as address patterns
	wire [7:0]  reg_rdata = {1'b0, reg_addr};
	wire [7:0]  fpage_rdata = {4'hA, fpage_sel};
	wire        op_ready, reg_we, fpage_we, zero_flag, done;
	wire [6:0]  reg_waddr;
	wire [7:0]  reg_wdata, fpage_wdata, accumulator;
	wire [3:0]  fpage_waddr;
	wire [10:0] pc, stack_top;
	wire [2:0]  stack_level;
	integer     bad_count = 0;
	integer     samples_checked = 0;
	integer     cyc = 0;
	mioc_core #(.SP_W(3)) mioc_core_i (
		.mclk        (mclk),
		.rst         (rst),
		.op_valid    (op_valid),
		.op          (op),
		.reg_addr    (reg_addr),
		.dest_bit    (dest_bit),
		.fpage_sel   (fpage_sel),
		.target      (target),
		.reg_rdata   (reg_rdata),
		.fpage_rdata (fpage_rdata),
		.op_ready    (op_ready),
		.reg_we      (reg_we),
		.reg_waddr   (reg_waddr),
		.reg_wdata   (reg_wdata),
		.fpage_we    (fpage_we),
		.fpage_waddr (fpage_waddr),
		.fpage_wdata (fpage_wdata),
		.accumulator (accumulator),
		.zero_flag   (zero_flag),
		.pc          (pc),
		.stack_level (stack_level),
		.stack_top   (stack_top),
		.done        (done)
	);
	always #20 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////
	// Wide enough for the packed multi-field compares
	task chk(input [31:0] g, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t: %h %h", $time, g, e);
			end
		end
	endtask
	// Issue one op, return at the falling edge after it is taken
	task run(input [2:0] o, input [6:0] a, input d, input [3:0] f,
		input [10:0] t);
		begin
			@(negedge mclk);
			op = o;
			reg_addr = a;
			dest_bit = d;
			fpage_sel = f;
			target = t;
			op_valid = 1'b1;
			@(negedge mclk);
			op_valid = 1'b0;
		end
	endtask
	task t_or;
		begin
			run(3'h1, 7'h00, 1'b0, 4'h0, 11'h000);
			chk(zero_flag, 1'b1);
			run(3'h3, 7'h00, 1'b0, 4'h5, 11'h000);
			chk(accumulator, 8'hA5);
			run(3'h1, 7'h0A, 1'b0, 4'h0, 11'h000);
			chk({zero_flag, accumulator}, 9'h0AF);
			run(3'h1, 7'h50, 1'b1, 4'h0, 11'h000);
			chk({reg_we, reg_waddr, reg_wdata, accumulator}, 24'hD0FFAF);
			chk({done, pc}, 12'h804);
		end
	endtask
	task t_page;
		begin
			run(3'h2, 7'h00, 1'b0, 4'hF, 11'h000);
			chk({fpage_we, fpage_waddr, fpage_wdata}, 13'h1FAF);
			run(3'h3, 7'h00, 1'b0, 4'h4, 11'h000);
			chk(accumulator, 8'hAF);
			run(3'h2, 7'h00, 1'b0, 4'h4, 11'h000);
			chk(fpage_we, 1'b0);
			run(3'h6, 7'h7F, 1'b0, 4'h0, 11'h000);
			chk({reg_we, reg_waddr, reg_wdata}, 16'hFFAF);
			chk({done, pc}, 12'h808);
		end
	endtask
	task t_jump;
		begin
			run(3'h4, 7'h00, 1'b0, 4'h0, 11'h7FF);
			chk({op_ready, pc}, 12'h7FF);
			@(negedge mclk);
			chk(done, 1'b1);
			run(3'h5, 7'h00, 1'b0, 4'h0, 11'h123);
			chk({stack_level, stack_top, pc}, 25'h0400123);
			run(3'h5, 7'h00, 1'b0, 4'h0, 11'h456);
			chk({stack_level, stack_top}, 14'h1124);
			@(negedge mclk);
			chk({done, op_ready, pc}, 13'h1C56);
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task complete_run;
		begin
			if (bad_count == 0 && samples_checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Hang guard, far above the few dozen cycles needed
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 1000) begin
			bad_count = bad_count + 1;
			complete_run;
		end
	end
	initial begin
		// Five rising edges in reset, release off the edge
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		chk({op_ready, stack_level, pc}, 15'h4000);
		t_or;
		t_page;
		t_jump;
		complete_run;
	end
endmodule // test_mioc_core
